// [core/aeah_pkg.sv]
package aeah_pkg;

    // controller-side exception actions (3-bit code)
    localparam logic [2:0] CA_IGNORE     = 3'h0;
    localparam logic [2:0] CA_ALARM      = 3'h1;
    localparam logic [2:0] CA_FAULT_ONLY = 3'h2;
    localparam logic [2:0] CA_STOP_PLAN  = 3'h3;
    localparam logic [2:0] CA_DRV_HALT   = 3'h4;
    localparam logic [2:0] CA_SHUTDOWN   = 3'h5;

    // drive-side exception actions
    typedef enum logic [1:0] {
        DA_IGNORE = 2'h0,
        DA_ALARM  = 2'h1,
        DA_MINOR  = 2'h2,
        DA_MAJOR  = 2'h3
    } aeah_dact_t;

    // stopping actions
    localparam logic [1:0] STOP_DECEL_HOLD    = 2'h0;
    localparam logic [1:0] STOP_DECEL_DISABLE = 2'h1;
    localparam logic [1:0] STOP_DISABLE_COAST = 2'h2;

    // stop sequencer states, gray along the path
    typedef enum logic [1:0] {
        ST_RUN  = 2'h0,
        ST_DECL = 2'h1,
        ST_HALT = 2'h3,
        ST_OFF  = 2'h2
    } aeah_state_t;

    // register offsets
    localparam logic [3:0] REG_STATUS  = 4'h0;
    localparam logic [3:0] REG_MASK    = 4'h1;
    localparam logic [3:0] REG_ALARM   = 4'h2;
    localparam logic [3:0] REG_FAULT   = 4'h3;
    localparam logic [3:0] REG_CTRL    = 4'h4;
    localparam logic [3:0] REG_ACTSEL  = 4'h5;
    localparam logic [3:0] REG_ACTDATA = 4'h6;
    localparam logic [3:0] REG_AXIS    = 4'h7;

    // ctrl bits
    localparam int CTRL_FAULT_RST = 0;
    localparam int CTRL_SHUT_RST  = 1;
    localparam int CTRL_ENABLE    = 2;

    // irq status bits
    localparam int IRQ_ALARM  = 0;
    localparam int IRQ_FAULT  = 1;
    localparam int IRQ_STOP   = 2;
    localparam int IRQ_REJECT = 3;

    // reset values
    localparam logic [3:0] MASK_RST = 4'h0;

    // decel time budget
    localparam int DECEL_TIME_US = 20;
    localparam int CLK_MHZ       = 100;
    localparam int DECEL_CYCLES  = DECEL_TIME_US * CLK_MHZ;

endpackage : aeah_pkg

// [core/aeah_exc_cell.sv]
`timescale 1ns/1ps
module aeah_exc_cell
    import aeah_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // condition and setting
    input  wire logic       cond,
    input  wire logic [2:0] cact,
    input  wire logic       fault_rst,
    // results
    output logic            alarm,
    output logic            fault,
    output logic            major
);
    typedef struct packed {
        logic fault;
    } aeah_cell_t;

    aeah_cell_t st_ff;
    aeah_cell_t nxt_st;
    aeah_dact_t dact;

    always_comb
    begin
        unique case (cact)
            CA_IGNORE:     dact = DA_IGNORE;
            CA_ALARM:      dact = DA_ALARM;
            CA_FAULT_ONLY: dact = DA_MINOR;
            default:       dact = DA_MAJOR;
        endcase
        nxt_st = st_ff;
        if (fault_rst && !cond)
        begin
            nxt_st.fault = 1'b0;
        end
        if (cond && (dact == DA_MINOR || dact == DA_MAJOR))
        begin
            nxt_st.fault = 1'b1;
        end
        alarm = cond && (dact == DA_ALARM);
        fault = st_ff.fault;
        major = st_ff.fault && (dact == DA_MAJOR);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule : aeah_exc_cell

// [core/aeah_top.sv]
`timescale 1ns/1ps
module aeah_top
    import aeah_pkg::*;
#(
    parameter int          N_EXC        = 8,
    parameter logic [7:0]  PROG_MASK    = 8'h0F,
    parameter logic [7:0]  CRIT_MASK    = 8'h03,
    parameter logic [7:0]  STARTUP_MASK = 8'h40,
    parameter logic [7:0]  WARN_MASK    = 8'h80,
    parameter logic [23:0] FIXED_ACT    = 24'h924924,
    parameter logic [15:0] DRV_STOP     = 16'h0000,
    parameter logic [23:0] STOP_ALLOW   = 24'hFFFFFF,
    parameter int          DECEL_CNT    = DECEL_CYCLES
)
(
    // clock and reset
    input  wire logic             CLK,
    input  wire logic             RST_N,
    // exception conditions from pins
    input  wire logic [N_EXC-1:0] EXC_IN,
    // register port
    input  wire logic [3:0]       ADDR,
    input  wire logic [31:0]      WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic      [31:0]      RDATA,
    // axis control
    output logic                  DECEL_REQ,
    output logic                  HOLD_REQ,
    output logic                  POWER_EN,
    output logic                  PLANNER_STOP,
    output logic                  IRQ
);
    localparam int CW = $clog2(DECEL_CNT + 1);

    typedef struct packed {
        logic [N_EXC-1:0]   sync1;
        logic [N_EXC-1:0]   sync2;
        logic [3*N_EXC-1:0] cact;
        logic [2*N_EXC-1:0] stop_sel;
        logic [2:0]         sel;
        logic [3:0]         irq_st;
        logic [3:0]         mask;
        logic               enable;
        logic               shut_lat;
        logic               plan_lat;
        logic [1:0]         act;
        aeah_state_t        state;
        logic [CW-1:0]      cnt;
        logic [31:0]        rdata;
        logic               decel;
        logic               hold;
        logic               pwr;
        logic               pstop;
        logic               irq;
    } aeah_top_t;

    aeah_top_t        st_ff;
    aeah_top_t        nxt_st;
    logic [N_EXC-1:0] alarm_v;
    logic [N_EXC-1:0] fault_v;
    logic [N_EXC-1:0] major_v;
    logic [3*N_EXC-1:0] eff_act;
    logic             fault_rst;

    assign fault_rst = WR && (ADDR == REG_CTRL) && WDATA[CTRL_FAULT_RST];

    generate
        for (genvar i = 0; i < N_EXC; i++)
        begin : g_exc
            // fixed action unless programmable
            assign eff_act[3*i +: 3] = PROG_MASK[i] ? st_ff.cact[3*i +: 3]
                                                    : FIXED_ACT[3*i +: 3];
            aeah_exc_cell u_cell (
                .clk       (CLK),
                .rst_n     (RST_N),
                .cond      (st_ff.sync2[i]),
                .cact      (eff_act[3*i +: 3]),
                .fault_rst (fault_rst),
                .alarm     (alarm_v[i]),
                .fault     (fault_v[i]),
                .major     (major_v[i])
            );
        end
    endgenerate

    always_comb
    begin
        logic [N_EXC-1:0] trig;
        logic [2:0]       wact;
        logic [1:0]       wstop;
        logic [1:0]       pick;
        logic             shut_hit;
        logic             plan_hit;
        logic             go;
        logic [3:0]       ev;
        logic [31:0]      rd;
        int               s;
        trig     = '0;
        wact     = WDATA[2:0];
        wstop    = WDATA[5:4];
        pick     = STOP_DISABLE_COAST;
        shut_hit = 1'b0;
        plan_hit = 1'b0;
        go       = 1'b0;
        ev       = '0;
        rd       = '0;
        s        = 0;
        nxt_st   = st_ff;

        nxt_st.sync1 = EXC_IN;
        nxt_st.sync2 = st_ff.sync1;

        // stop triggers
        for (int i = 0; i < N_EXC; i++)
        begin
            // startup and warning groups never stop
            trig[i] = major_v[i] && !STARTUP_MASK[i] && !WARN_MASK[i];
            if (trig[i] && eff_act[3*i +: 3] == CA_SHUTDOWN)
            begin
                shut_hit = 1'b1;
            end
            if (trig[i] && eff_act[3*i +: 3] == CA_STOP_PLAN)
            begin
                plan_hit = 1'b1;
            end
        end
        // lowest-numbered trigger selects the stop action
        for (int i = N_EXC - 1; i >= 0; i--)
        begin
            if (trig[i])
            begin
                s = i;
                go = 1'b1;
            end
        end
        if (go)
        begin
            if (eff_act[3*s +: 3] == CA_DRV_HALT || eff_act[3*s +: 3] == CA_SHUTDOWN)
            begin
                pick = DRV_STOP[2*s +: 2];
            end
            else
            begin
                pick = st_ff.stop_sel[2*s +: 2];
            end
        end

        // register writes
        if (WR)
        begin
            unique case (ADDR)
                REG_STATUS: nxt_st.irq_st = st_ff.irq_st & ~WDATA[3:0];
                REG_MASK:   nxt_st.mask = WDATA[3:0];
                REG_CTRL:
                begin
                    nxt_st.enable = WDATA[CTRL_ENABLE];
                    if (WDATA[CTRL_SHUT_RST])
                    begin
                        nxt_st.shut_lat = 1'b0;
                    end
                    if (WDATA[CTRL_FAULT_RST])
                    begin
                        nxt_st.plan_lat = 1'b0;
                    end
                end
                REG_ACTSEL: nxt_st.sel = WDATA[2:0];
                REG_ACTDATA:
                begin
                    // refuse ignore, alarm, fault-only or stop-plan on critical, unsupported stop choices
                    if ((wact == CA_IGNORE || wact == CA_ALARM || wact == CA_FAULT_ONLY
                         || wact == CA_STOP_PLAN) && CRIT_MASK[st_ff.sel])
                    begin
                        ev[IRQ_REJECT] = 1'b1;
                    end
                    else if (wact > CA_SHUTDOWN || wstop > STOP_DISABLE_COAST
                             || !STOP_ALLOW[3*st_ff.sel + 32'(wstop)])
                    begin
                        ev[IRQ_REJECT] = 1'b1;
                    end
                    else
                    begin
                        nxt_st.cact[3*st_ff.sel +: 3]     = wact;
                        nxt_st.stop_sel[2*st_ff.sel +: 2] = wstop;
                    end
                end
                default: ;
            endcase
        end

        // a fault reset in this cycle keeps either latch from arming
        if (shut_hit && !fault_rst)
        begin
            nxt_st.shut_lat = 1'b1;
        end
        if (plan_hit && !fault_rst)
        begin
            nxt_st.plan_lat = 1'b1;
        end

        // stop sequencer
        unique case (st_ff.state)
            ST_RUN:
            begin
                nxt_st.pwr = st_ff.enable && !st_ff.shut_lat;
                if (go)
                begin
                    nxt_st.act = pick;
                    nxt_st.pwr = 1'b0;
                    ev[IRQ_STOP] = 1'b1;
                    if (pick == STOP_DISABLE_COAST)
                    begin
                        nxt_st.state = ST_OFF;
                        nxt_st.pwr   = 1'b0;
                    end
                    else
                    begin
                        nxt_st.state = ST_DECL;
                        nxt_st.decel = 1'b1;
                        nxt_st.cnt   = CW'(DECEL_CNT);
                    end
                end
            end
            ST_DECL:
            begin
                // no restart while decelerating
                if (st_ff.cnt != '0)
                begin
                    nxt_st.cnt = st_ff.cnt - 1'b1;
                end
                else
                begin
                    nxt_st.decel = 1'b0;
                    if (st_ff.act == STOP_DECEL_HOLD && !st_ff.shut_lat)
                    begin
                        nxt_st.state = ST_HALT;
                        nxt_st.hold  = 1'b1;
                    end
                    else
                    begin
                        nxt_st.state = ST_OFF;
                        nxt_st.pwr   = 1'b0;
                    end
                end
            end
            ST_HALT:
            begin
                if (!go)
                begin
                    nxt_st.state = ST_RUN;
                    nxt_st.hold  = 1'b0;
                end
            end
            ST_OFF:
            begin
                if (!go && !st_ff.shut_lat)
                begin
                    nxt_st.state = ST_RUN;
                end
            end
        endcase

        // interrupt events
        ev[IRQ_ALARM] = |alarm_v;
        ev[IRQ_FAULT] = |fault_v;
        nxt_st.irq_st = nxt_st.irq_st | ev;
        nxt_st.irq    = |(nxt_st.irq_st & ~nxt_st.mask);
        nxt_st.pstop  = nxt_st.plan_lat;

        // read data
        if (RD)
        begin
            unique case (ADDR)
                REG_STATUS:  rd[3:0] = st_ff.irq_st;
                REG_MASK:    rd[3:0] = st_ff.mask;
                REG_ALARM:   rd[N_EXC-1:0] = alarm_v;
                REG_FAULT:   rd[N_EXC-1:0] = fault_v;
                REG_CTRL:    rd[CTRL_ENABLE] = st_ff.enable;
                REG_ACTSEL:  rd[2:0] = st_ff.sel;
                REG_ACTDATA:
                begin
                    rd[2:0] = eff_act[3*st_ff.sel +: 3];
                    rd[5:4] = st_ff.stop_sel[2*st_ff.sel +: 2];
                end
                REG_AXIS:
                begin
                    rd[1:0] = st_ff.state;
                    rd[2]   = st_ff.shut_lat;
                    rd[3]   = st_ff.pwr;
                end
                default: rd = '0;
            endcase
        end
        nxt_st.rdata = rd;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            st_ff      <= '0;
            st_ff.mask <= MASK_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign RDATA        = st_ff.rdata;
    assign DECEL_REQ    = st_ff.decel;
    assign HOLD_REQ     = st_ff.hold;
    assign POWER_EN     = st_ff.pwr;
    assign PLANNER_STOP = st_ff.pstop;
    assign IRQ          = st_ff.irq;
endmodule : aeah_top

// [sim/aeah_top_chk.sv]
`timescale 1ns/1ps
module aeah_top_chk
    import aeah_pkg::*;
#(
    parameter int N_EXC     = 8,
    parameter int DECEL_CNT = 8
)
(
    // clock and reset
    input wire logic             CLK,
    input wire logic             RST_N,
    // conditions and register port
    input wire logic [N_EXC-1:0] EXC_IN,
    input wire logic [3:0]       ADDR,
    input wire logic [31:0]      WDATA,
    input wire logic             WR,
    input wire logic             RD,
    input wire logic [31:0]      RDATA,
    // axis control
    input wire logic             DECEL_REQ,
    input wire logic             HOLD_REQ,
    input wire logic             POWER_EN,
    input wire logic             PLANNER_STOP,
    input wire logic             IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // length of the current decel run
    logic [15:0] dcnt_ff;
    always_ff @(posedge CLK)
        if (!RST_N || !DECEL_REQ)
            dcnt_ff <= 16'h0;
        else
            dcnt_ff <= dcnt_ff + 16'h1;

    sequence s_decel_end;
        DECEL_REQ ##1 !DECEL_REQ;
    endsequence
    sequence s_mask_all;
        WR && ADDR == REG_MASK && WDATA[3:0] == 4'hF;
    endsequence

    a_decel_no_power: assert property (DECEL_REQ |-> !POWER_EN)
        else $error("power on while decelerating");
    a_hold_exclusive: assert property (HOLD_REQ |-> !DECEL_REQ && !POWER_EN)
        else $error("hold overlaps decel or power");
    a_hold_after_decel: assert property ($rose(HOLD_REQ) |-> $past(DECEL_REQ))
        else $error("hold without decel");
    a_decel_exit: assert property (s_decel_end |-> !POWER_EN)
        else $error("power back at end of decel");
    a_decel_bounded: assert property (dcnt_ff <= 16'(DECEL_CNT + 2))
        else $error("decel too long");
    a_unmapped_zero: assert property (RD && ADDR[3] |=> RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_idle_rdata: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data without read");
    a_mask_quiets_irq: assert property (s_mask_all |-> ##2 !IRQ)
        else $error("irq despite full mask");
    a_axis_mirror: assert property (RD && ADDR == REG_AXIS |=> RDATA[3] == $past(POWER_EN)
        && RDATA[0] == ($past(DECEL_REQ) | $past(HOLD_REQ)))
        else $error("axis word disagrees with outputs");
    a_planner_latched: assert property (PLANNER_STOP && !WR && !$past(WR) |=> PLANNER_STOP)
        else $error("planner stop dropped");
    c_hold: cover property ($rose(HOLD_REQ));
endmodule : aeah_top_chk

bind aeah_top aeah_top_chk #(.N_EXC(N_EXC), .DECEL_CNT(DECEL_CNT)) u_chk (
    .CLK(CLK), .RST_N(RST_N), .EXC_IN(EXC_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .DECEL_REQ(DECEL_REQ), .HOLD_REQ(HOLD_REQ), .POWER_EN(POWER_EN),
    .PLANNER_STOP(PLANNER_STOP), .IRQ(IRQ));

// [sim/aeah_ctl_model.sv]
`timescale 1ns/1ps
module aeah_ctl_model
    import aeah_pkg::*;
#(
    parameter logic [7:0] CRUISE  = 8'h40,
    parameter logic [7:0] MAX_DEC = 8'h08
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // planner
    input  wire logic       planner_stop,
    output logic      [7:0] speed
);
    logic [7:0] speed_ff;
    assign speed = speed_ff;
    // planned motion ramps down at max decel
    always_ff @(posedge clk)
        if (!rst_n || !planner_stop)
            speed_ff <= CRUISE;
        else if (speed_ff > MAX_DEC)
            speed_ff <= speed_ff - MAX_DEC;
        else
            speed_ff <= 8'h00;
endmodule : aeah_ctl_model

// [sim/test_axis_exception_action_handler.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) n_compared++; if ((s) !== (e)) begin $display("BAD %s exp %0h got %0h", n, e, s); err_count++; end
module test_axis_exception_action_handler
    import aeah_pkg::*;
;
    logic        CLK, RST_N, WR, RD, DECEL_REQ, HOLD_REQ, POWER_EN, PLANNER_STOP, IRQ;
    logic [7:0]  EXC_IN, speed;
    logic [3:0]  ADDR;
    logic [31:0] WDATA, RDATA, d;
    int          err_count, n_compared;

    aeah_top #(.DECEL_CNT(8)) dut (
        .CLK(CLK), .RST_N(RST_N), .EXC_IN(EXC_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .DECEL_REQ(DECEL_REQ), .HOLD_REQ(HOLD_REQ),
        .POWER_EN(POWER_EN), .PLANNER_STOP(PLANNER_STOP), .IRQ(IRQ));
    aeah_ctl_model ctl (.clk(CLK), .rst_n(RST_N), .planner_stop(PLANNER_STOP), .speed(speed));

    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask : cyc
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= v;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    task setact(input logic [2:0] s, input logic [7:0] v);
        wr(REG_ACTSEL, {29'h0, s});
        wr(REG_ACTDATA, {24'h0, v});
    endtask : setact
    task results;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    task t_reset;
        rd(REG_MASK);
        `CHK("mask", 4'h0, d[3:0])
        rd(REG_AXIS);
        `CHK("axis", 32'h0, d)
        rd(4'h9);
        `CHK("unmapped", 32'h0, d)
        $display("reset test done");
    endtask : t_reset
    task t_soft(input logic [2:0] a, input logic ea, input logic ef);
        wr(REG_STATUS, 32'hF);
        setact(3'h3, {5'h0, a});
        wr(REG_CTRL, 32'h5);
        cyc(4);
        EXC_IN[3] <= 1'b1;
        cyc(6);
        rd(REG_ALARM);
        `CHK("alarm on", ea, d[3])
        rd(REG_FAULT);
        `CHK("fault on", ef, d[3])
        `CHK("no stop", 1'b1, POWER_EN)
        rd(REG_STATUS);
        `CHK("status", {ef, ea}, d[1:0])
        @(posedge CLK);
        EXC_IN[3] <= 1'b0;
        cyc(6);
        rd(REG_ALARM);
        `CHK("alarm off", 1'b0, d[3])
        rd(REG_FAULT);
        `CHK("fault held", ef, d[3])
        wr(REG_CTRL, 32'h5);
        rd(REG_FAULT);
        `CHK("fault reset", 1'b0, d[3])
        $display("soft action %0d done", a);
    endtask : t_soft
    task t_major(input logic [2:0] a, input logic [1:0] st, input logic edec, input logic ehold, input logic epl);
        setact(3'h3, {2'h0, st, 1'b0, a});
        wr(REG_CTRL, 32'h4);
        cyc(4);
        `CHK("power on", 1'b1, POWER_EN)
        EXC_IN[3] <= 1'b1;
        cyc(6);
        `CHK("decel", edec, DECEL_REQ)
        `CHK("planner", epl, PLANNER_STOP)
        `CHK("power off", 1'b0, POWER_EN)
        cyc(12);
        `CHK("hold", ehold, HOLD_REQ)
        `CHK("speed", epl ? 8'h00 : 8'h40, speed)
        EXC_IN[3] <= 1'b0;
        cyc(4);
        wr(REG_CTRL, 32'h5);
        cyc(4);
        `CHK("restart", 1'b1, POWER_EN)
        `CHK("planner clear", 1'b0, PLANNER_STOP)
        $display("major action %0d stop %0d done", a, st);
    endtask : t_major
    task t_shutdown;
        setact(3'h3, 8'h05);
        wr(REG_CTRL, 32'h4);
        cyc(4);
        EXC_IN[3] <= 1'b1;
        cyc(18);
        `CHK("shut power", 1'b0, POWER_EN)
        EXC_IN[3] <= 1'b0;
        cyc(4);
        wr(REG_CTRL, 32'h5);
        cyc(4);
        `CHK("still off", 1'b0, POWER_EN)
        rd(REG_AXIS);
        `CHK("shut latched", 1'b1, d[2])
        wr(REG_CTRL, 32'h7);
        cyc(4);
        `CHK("resumed", 1'b1, POWER_EN)
        $display("shutdown test done");
    endtask : t_shutdown
    task t_groups;
        EXC_IN[7:6] <= 2'h3;
        cyc(8);
        `CHK("group stop", 1'b0, DECEL_REQ)
        `CHK("group power", 1'b1, POWER_EN)
        EXC_IN <= 8'h10;
        cyc(6);
        `CHK("fixed stop", 1'b1, DECEL_REQ)
        EXC_IN <= 8'h00;
        cyc(14);
        wr(REG_CTRL, 32'h5);
        $display("group test done");
    endtask : t_groups
    task t_reject(input logic [2:0] s, input logic [7:0] v);
        wr(REG_STATUS, 32'hF);
        setact(s, v);
        rd(REG_STATUS);
        `CHK("reject", 1'b1, d[3])
        `CHK("irq raised", 1'b1, IRQ)
    endtask : t_reject
    task t_irq;
        wr(REG_MASK, 32'hF);
        cyc(2);
        `CHK("irq masked", 1'b0, IRQ)
        wr(REG_MASK, 32'h0);
        cyc(2);
        `CHK("irq unmasked", 1'b1, IRQ)
        wr(REG_STATUS, 32'h8);
        rd(REG_STATUS);
        `CHK("status cleared", 4'h0, d[3:0])
        `CHK("irq cleared", 1'b0, IRQ)
        $display("irq test done");
    endtask : t_irq

    initial
    begin
        err_count = 0;
        n_compared = 0;
        RST_N = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 4'h0;
        WDATA = 32'h0;
        EXC_IN = 8'h00;
        cyc(3);
        RST_N <= 1'b1;
        t_reset();
        t_soft(3'h0, 1'b0, 1'b0);
        t_soft(3'h1, 1'b1, 1'b0);
        t_soft(3'h2, 1'b0, 1'b1);
        t_major(3'h3, 2'h0, 1'b1, 1'b1, 1'b1);
        t_major(3'h3, 2'h1, 1'b1, 1'b0, 1'b1);
        t_major(3'h3, 2'h2, 1'b0, 1'b0, 1'b1);
        t_major(3'h4, 2'h2, 1'b1, 1'b1, 1'b0);
        t_shutdown();
        t_groups();
        t_reject(3'h0, 8'h01);
        t_reject(3'h1, 8'h03);
        t_reject(3'h3, 8'h06);
        t_reject(3'h3, 8'h33);
        t_irq();
        results();
    end

    initial
    begin
        cyc(3000);
        err_count++;
        results();
    end
endmodule : test_axis_exception_action_handler
